/* rtl/tbs_serdes.sv */
// 10Base-T serializer mode with AHB-Lite register slave
`timescale 1ns/1ps
module tbs_serdes
  import tbs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        analog_rx_plus,
  input  wire logic        analog_rx_minus,
  output logic             tx_plus_pin,
  output logic             tx_minus_pin,
  output logic             tx_plus_preemphasis_pin,
  output logic             tx_minus_preemphasis_pin,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   a_sel;
    logic                   a_wr;
    logic [7:0]             a_addr;
    logic [31:0]            rdata;
    logic [MODE_W-1:0]      mode;
    logic [7:0]             sync_pattern_config;
    logic [CNT_W-1:0]       rx_shift_count_config;
    logic [CNT_W-1:0]       tx_bit_count_config;
    logic [NFLG-1:0]        flags;
    logic [NFLG-1:0]        inten;
    logic [SHIFT_W-1:0]     rx_buffer;
    logic [CNT_W-1:0]       rx_bit_count;
    logic [SHIFT_W-1:0]     tx_buffer;
    logic                   hi_wr;
    logic                   lo_wr;
    tbs_rx_t                rx_state;
    logic [7:0]             rx_win;
    logic [SHIFT_W-1:0]     rx_sh;
    logic [CNT_W-1:0]       rx_n;
    tbs_tx_t                tx_state;
    logic [SHIFT_W-1:0]     tx_sh;
    logic [CNT_W-1:0]       tx_n;
    logic [CNT_W-1:0]       tx_len;
    logic                   tx_half;
    logic [2:0]             tx_eopc;
    logic                   line_on;
    logic                   txp;
    logic                   txm;
    logic [PREEMPH_CYC-1:0] dly_p;
    logic [PREEMPH_CYC-1:0] dly_m;
    logic [PREEMPH_CYC-1:0] dly_on;
    logic                   irq;
  } tbs_st_t;

  tbs_st_t st_ff;
  tbs_st_t nxt_st;

  tbs_rx_if rxl ();

  tbs_rx_front u_front (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .analog_rx_plus  (analog_rx_plus),
    .analog_rx_minus (analog_rx_minus),
    .rx              (rxl.front)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Zero and values above the shifter width both mean a full word
  function automatic logic [CNT_W-1:0] eff_cnt(input logic [CNT_W-1:0] c);
    if (c == '0 || c > CNT_W'(SHIFT_W)) begin
      eff_cnt = CNT_W'(SHIFT_W);
    end else begin
      eff_cnt = c;
    end
  endfunction

  logic                   is10;
  logic                   rx_en;
  logic                   rbit;
  logic                   enc;
  logic                   wr;
  logic [NFLG-1:0]        set_f;
  logic [NFLG-1:0]        clr_f;
  logic [SHIFT_W-1:0]     rx_next;
  logic [CNT_W-1:0]       n_inc;

  always_comb begin
    nxt_st  = st_ff;
    set_f   = '0;
    clr_f   = '0;
    is10    = st_ff.mode[3:0] == PRS_10BT;
    rx_en   = is10 &&
              st_ff.mode[MODE_MCLK_LSB +: 2] == MCLK_80;
    rbit    = rxl.bit_val ^ st_ff.mode[MODE_POL_BIT];
    rx_next = {rbit, st_ff.rx_sh[SHIFT_W-1:1]};
    n_inc   = st_ff.rx_n + CNT_W'(1);
    wr      = st_ff.a_sel && st_ff.a_wr;

    // --------------------------------------------------------------
    // Bus address phase; read data is captured here for the data phase
    // --------------------------------------------------------------
    nxt_st.a_sel  = hsel && htrans[1] && hready;
    nxt_st.a_wr   = hwrite;
    nxt_st.a_addr = haddr[7:0];
    nxt_st.rdata  = '0;
    if (haddr[7:0] == OFS_MODE) begin
      nxt_st.rdata[MODE_W-1:0] = st_ff.mode;
    end else if (haddr[7:0] == OFS_SYNC) begin
      nxt_st.rdata[7:0] = st_ff.sync_pattern_config;
    end else if (haddr[7:0] == OFS_RXCFG) begin
      nxt_st.rdata[CNT_W-1:0] = st_ff.rx_shift_count_config;
    end else if (haddr[7:0] == OFS_RXCNT) begin
      nxt_st.rdata[CNT_W-1:0]     = st_ff.rx_bit_count;
      nxt_st.rdata[RXCNT_CRS_BIT] = rxl.carrier;
    end else if (haddr[7:0] == OFS_FLAGS) begin
      nxt_st.rdata[NFLG-1:0] = st_ff.flags;
    end else if (haddr[7:0] == OFS_INTEN) begin
      nxt_st.rdata[NFLG-1:0] = st_ff.inten;
    end else if (haddr[7:0] == OFS_RXBUF) begin
      nxt_st.rdata[SHIFT_W-1:0] = st_ff.rx_buffer;
    end else if (haddr[7:0] == OFS_TXBUFH) begin
      nxt_st.rdata[7:0] = st_ff.tx_buffer[SHIFT_W-1:8];
    end else if (haddr[7:0] == OFS_TXBUFL) begin
      nxt_st.rdata[7:0] = st_ff.tx_buffer[7:0];
    end else if (haddr[7:0] == OFS_TXCFG) begin
      nxt_st.rdata[CNT_W-1:0] = st_ff.tx_bit_count_config;
    end

    // --------------------------------------------------------------
    // Bus data phase writes
    // --------------------------------------------------------------
    if (wr) begin
      if (st_ff.a_addr == OFS_MODE) begin
        nxt_st.mode = hwdata[MODE_W-1:0];
      end else if (st_ff.a_addr == OFS_SYNC) begin
        nxt_st.sync_pattern_config = hwdata[7:0];
      end else if (st_ff.a_addr == OFS_RXCFG) begin
        nxt_st.rx_shift_count_config = hwdata[CNT_W-1:0];
      end else if (st_ff.a_addr == OFS_FLAGS) begin
        clr_f = hwdata[NFLG-1:0];
      end else if (st_ff.a_addr == OFS_INTEN) begin
        nxt_st.inten = hwdata[NFLG-1:0];
      end else if (st_ff.a_addr == OFS_TXBUFH) begin
        nxt_st.tx_buffer[SHIFT_W-1:8] = hwdata[7:0];
        nxt_st.hi_wr                  = 1'b1;
      end else if (st_ff.a_addr == OFS_TXBUFL) begin
        nxt_st.tx_buffer[7:0] = hwdata[7:0];
        nxt_st.lo_wr          = 1'b1;
      end else if (st_ff.a_addr == OFS_TXCFG) begin
        nxt_st.tx_bit_count_config = hwdata[CNT_W-1:0];
      end
    end

    // --------------------------------------------------------------
    // Receive
    // --------------------------------------------------------------
    if (rxl.link_pulse && rx_en) begin
      set_f[FLG_LINK] = 1'b1;
    end
    if (!rx_en) begin
      nxt_st.rx_state = TBS_RX_HUNT;
      nxt_st.rx_win   = '0;
    end else begin
      case (st_ff.rx_state)
        TBS_RX_HUNT: begin
          if (rxl.bit_valid) begin
            nxt_st.rx_win = {st_ff.rx_win[6:0], rbit};
            if ({st_ff.rx_win[6:0], rbit} == SFD_PATTERN) begin
              nxt_st.rx_state = TBS_RX_DATA;
              nxt_st.rx_n     = '0;
              nxt_st.rx_sh    = '0;
            end
          end
        end
        TBS_RX_DATA: begin
          // Matching stays off here so payload cannot restart a frame
          if (rxl.eop) begin
            nxt_st.rx_state     = TBS_RX_HUNT;
            nxt_st.rx_win       = '0;
            nxt_st.rx_bit_count = st_ff.rx_n;
            nxt_st.rx_buffer    = st_ff.rx_sh >>
                                  (CNT_W'(SHIFT_W) - st_ff.rx_n);
            set_f[FLG_RXEOP]    = 1'b1;
            set_f[FLG_RX_BUFFER_FULL_FLAG]     = 1'b1;
          end else if (rxl.bit_valid) begin
            nxt_st.rx_sh = rx_next;
            nxt_st.rx_n  = n_inc;
            if (n_inc == eff_cnt(st_ff.rx_shift_count_config)) begin
              nxt_st.rx_buffer    = rx_next;
              nxt_st.rx_bit_count = n_inc;
              nxt_st.rx_n         = '0;
              set_f[FLG_RX_BUFFER_FULL_FLAG]     = 1'b1;
            end
          end
        end
        default: nxt_st.rx_state = TBS_RX_HUNT;
      endcase
    end

    // --------------------------------------------------------------
    // Transmit
    // --------------------------------------------------------------
    enc         = 1'b0;
    nxt_st.txp  = 1'b0;
    nxt_st.txm  = 1'b0;
    case (st_ff.tx_state)
      TBS_TX_IDLE: begin
        if (nxt_st.hi_wr && nxt_st.lo_wr) begin
          nxt_st.tx_state = TBS_TX_SHIFT;
          nxt_st.tx_sh    = nxt_st.tx_buffer;
          nxt_st.tx_len   = eff_cnt(st_ff.tx_bit_count_config);
          nxt_st.tx_n     = '0;
          nxt_st.tx_half  = 1'b0;
          nxt_st.hi_wr    = 1'b0;
          nxt_st.lo_wr    = 1'b0;
          set_f[FLG_TX_BUFFER_EMPTY_FLAG] = 1'b1;
        end
      end
      TBS_TX_SHIFT: begin
        // Ones go low then high; the encoder is skipped outside 10Base-T
        enc = is10 ? (st_ff.tx_half ? st_ff.tx_sh[0] : ~st_ff.tx_sh[0])
                   : st_ff.tx_sh[0];
        nxt_st.txp     = enc;
        nxt_st.txm     = is10 & ~enc;
        nxt_st.tx_half = is10 ? ~st_ff.tx_half : 1'b1;
        if (st_ff.tx_half || !is10) begin
          nxt_st.tx_half = 1'b0;
          nxt_st.tx_sh   = st_ff.tx_sh >> 1;
          nxt_st.tx_n    = st_ff.tx_n + CNT_W'(1);
          if (st_ff.tx_n + CNT_W'(1) == st_ff.tx_len) begin
            if (nxt_st.hi_wr && nxt_st.lo_wr) begin
              nxt_st.tx_sh    = nxt_st.tx_buffer;
              nxt_st.tx_len   = eff_cnt(st_ff.tx_bit_count_config);
              nxt_st.tx_n     = '0;
              nxt_st.hi_wr    = 1'b0;
              nxt_st.lo_wr    = 1'b0;
              set_f[FLG_TX_BUFFER_EMPTY_FLAG] = 1'b1;
            end else begin
              set_f[FLG_TX_END_PACKET_FLAG] = 1'b1;
              nxt_st.tx_eopc   = 3'(TX_EOP_CYC - 1);
              nxt_st.tx_state  = is10 ? TBS_TX_EOP : TBS_TX_IDLE;
            end
          end
        end
      end
      TBS_TX_EOP: begin
        // Line held positive until the countdown expires
        nxt_st.txp     = 1'b1;
        nxt_st.tx_eopc = st_ff.tx_eopc - 3'h1;
        if (st_ff.tx_eopc == 3'h0) begin
          nxt_st.tx_state = TBS_TX_IDLE;
        end
      end
      default: nxt_st.tx_state = TBS_TX_IDLE;
    endcase
    nxt_st.line_on = st_ff.tx_state != TBS_TX_IDLE;

    // Pre-emphasis copies the line one half-bit later, inverted
    nxt_st.dly_p  = PREEMPH_CYC'({st_ff.dly_p, st_ff.txp});
    nxt_st.dly_m  = PREEMPH_CYC'({st_ff.dly_m, st_ff.txm});
    nxt_st.dly_on = PREEMPH_CYC'({st_ff.dly_on, st_ff.line_on & is10});

    // --------------------------------------------------------------
    // Flags: a hardware set beats a software clear in the same cycle
    // --------------------------------------------------------------
    nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;
    nxt_st.irq   = |(nxt_st.flags & st_ff.inten);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff                       <= '0;
      st_ff.mode                  <= MODE_RST;
      st_ff.rx_shift_count_config <= CFG_RST;
      st_ff.tx_bit_count_config   <= CFG_RST;
      st_ff.flags                 <= FLG_RST;
      st_ff.rx_state              <= TBS_RX_HUNT;
      st_ff.tx_state              <= TBS_TX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_ff.rdata;
  assign tx_plus_pin  = st_ff.txp;
  assign tx_minus_pin = st_ff.txm;
  assign tx_plus_preemphasis_pin  =
    st_ff.dly_on[PREEMPH_CYC-1] & ~st_ff.dly_p[PREEMPH_CYC-1];
  assign tx_minus_preemphasis_pin =
    st_ff.dly_on[PREEMPH_CYC-1] & ~st_ff.dly_m[PREEMPH_CYC-1];
  assign irq = st_ff.irq;

endmodule // tbs_serdes

/* pkg/tbs_pkg.sv */
// Constants, register map and types for the 10Base-T serializer mode
package tbs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 50;
  localparam int PREEMPH_NS  = 50;
  localparam int PREEMPH_CYC = (PREEMPH_NS / CLK_NS < 1) ? 1 :
                               PREEMPH_NS / CLK_NS;
  localparam int TX_EOP_NS   = 250;
  localparam int TX_EOP_CYC  = (TX_EOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQ_EOP_NS   = 200;
  localparam int SQ_EOP_CYC  = (SQ_EOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LP_MAX_NS   = 200;
  localparam int LP_MAX_CYC  = (LP_MAX_NS / CLK_NS < 1) ? 1 :
                               LP_MAX_NS / CLK_NS;
  localparam int BIT_GAP_CYC = 2;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 16;
  localparam int CNT_W   = 5;
  localparam int NFLG    = 5;
  localparam int SQ_W    = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_SYNC   = 8'h04;
  localparam logic [7:0] OFS_RXCFG  = 8'h08;
  localparam logic [7:0] OFS_RXCNT  = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_INTEN  = 8'h14;
  localparam logic [7:0] OFS_RXBUF  = 8'h18;
  localparam logic [7:0] OFS_TXBUFH = 8'h1C;
  localparam logic [7:0] OFS_TXBUFL = 8'h20;
  localparam logic [7:0] OFS_TXCFG  = 8'h24;

  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam int         MODE_W        = 7;
  localparam int         MODE_POL_BIT  = 4;
  localparam int         MODE_MCLK_LSB = 5;
  localparam logic [3:0] PRS_10BT      = 4'h1;
  localparam logic [1:0] MCLK_80       = 2'h1;
  localparam int         RXCNT_CRS_BIT = 5;
  localparam logic [7:0] SFD_PATTERN   = 8'hD5;

  localparam int FLG_RX_BUFFER_FULL_FLAG  = 0;
  localparam int FLG_TX_BUFFER_EMPTY_FLAG  = 1;
  localparam int FLG_TX_END_PACKET_FLAG = 2;
  localparam int FLG_RXEOP = 3;
  localparam int FLG_LINK  = 4;

  localparam logic [MODE_W-1:0]  MODE_RST  = 7'h00;
  localparam logic [CNT_W-1:0]   CFG_RST   = 5'h10;
  localparam logic [NFLG-1:0]    FLG_RST   = 5'h00;
  localparam logic [SHIFT_W-1:0] WORD_FULL = 16'h0010;

  typedef enum logic [1:0] { TBS_TX_IDLE, TBS_TX_SHIFT, TBS_TX_EOP } tbs_tx_t;
  typedef enum logic       { TBS_RX_HUNT, TBS_RX_DATA }              tbs_rx_t;

endpackage

/* pkg/tbs_rx_if.sv */
// Recovered bit stream and squelch status between line front and core
`timescale 1ns/1ps
interface tbs_rx_if;
  logic bit_valid;
  logic bit_val;
  logic carrier;
  logic eop;
  logic link_pulse;
  logic link_pol;

  modport front (output bit_valid, bit_val, carrier, eop, link_pulse,
                 link_pol);
  modport core  (input  bit_valid, bit_val, carrier, eop, link_pulse,
                 link_pol);
endinterface

/* rtl/tbs_rx_front.sv */
// Squelch, end-of-packet detection and clock/data recovery
`timescale 1ns/1ps
module tbs_rx_front
  import tbs_pkg::*;
(
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  analog_rx_plus,
  input  wire logic  analog_rx_minus,
  tbs_rx_if.front    rx
);

  typedef struct packed {
    logic            prv;
    logic [1:0]      gap;
    logic [SQ_W-1:0] idle;
    logic [SQ_W-1:0] len;
    logic            on;
    logic            lvl;
    logic            bv;
    logic            bit_v;
    logic            crs;
    logic            eop;
    logic            lp;
    logic            lpol;
  } tbs_fe_t;

  tbs_fe_t st_ff;
  tbs_fe_t nxt_st;
  logic    carrier;

  // ----------------------------------------------------------------
  // Squelch and recovery
  // ----------------------------------------------------------------
  // A valid differential level has the two comparators disagree
  assign carrier = analog_rx_plus ^ analog_rx_minus;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.bv  = 1'b0;
    nxt_st.eop = 1'b0;
    nxt_st.lp  = 1'b0;
    nxt_st.prv = analog_rx_plus;
    nxt_st.crs = st_ff.on;
    if (st_ff.gap != 2'(BIT_GAP_CYC)) begin
      nxt_st.gap = st_ff.gap + 2'h1;
    end
    // Mid-bit edges are two cycles apart; cell edges in between are
    // skipped because the gap has not elapsed yet
    if (carrier && analog_rx_plus != st_ff.prv &&
        st_ff.gap == 2'(BIT_GAP_CYC)) begin
      nxt_st.bv    = st_ff.on;
      nxt_st.bit_v = analog_rx_plus;
      nxt_st.gap   = 2'h1;
    end
    if (carrier) begin
      nxt_st.idle = '0;
      nxt_st.on   = 1'b1;
      if (!st_ff.on) begin
        nxt_st.lvl = analog_rx_plus;
      end
      if (st_ff.len != SQ_W'(LP_MAX_CYC + 1)) begin
        nxt_st.len = st_ff.len + SQ_W'(1);
      end
    end else if (st_ff.on) begin
      nxt_st.idle = st_ff.idle + SQ_W'(1);
      if (st_ff.idle == SQ_W'(SQ_EOP_CYC - 1)) begin
        nxt_st.on  = 1'b0;
        nxt_st.len = '0;
        // Short bursts are link pulses, longer ones end a packet
        if (st_ff.len <= SQ_W'(LP_MAX_CYC)) begin
          nxt_st.lp   = 1'b1;
          nxt_st.lpol = st_ff.lvl;
        end else begin
          nxt_st.eop = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rx.bit_valid  = st_ff.bv;
  assign rx.bit_val    = st_ff.bit_v;
  assign rx.carrier    = st_ff.crs;
  assign rx.eop        = st_ff.eop;
  assign rx.link_pulse = st_ff.lp;
  assign rx.link_pol   = st_ff.lpol;

endmodule // tbs_rx_front

/* sim/tbs_serdes_props.sv */
// Assertion checker on the serializer's bus and line outputs
`timescale 1ns/1ps
module tbs_serdes_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_plus_pin,
  input wire logic tx_minus_pin,
  input wire logic tx_plus_preemphasis_pin,
  input wire logic tx_minus_preemphasis_pin
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Line coding, pre-emphasis and bus answer
  // ----------------------------------------------------------------
  pre_plus_a: assert property (
    tx_plus_preemphasis_pin |-> !$past(tx_plus_pin))
    else $error("plus pre-emphasis is not the delayed inverse");
  pre_minus_a: assert property (
    tx_minus_preemphasis_pin |-> !$past(tx_minus_pin))
    else $error("minus pre-emphasis is not the delayed inverse");
  pre_follow_a: assert property (
    $fell(tx_plus_pin) && tx_minus_pin |=> tx_plus_preemphasis_pin)
    else $error("plus pre-emphasis missed a falling line");
  diff_pair_a: assert property (
    tx_minus_pin |-> !tx_plus_pin)
    else $error("both transmit legs high");
  minus_run_a: assert property (
    tx_minus_pin [*2] |=> !tx_minus_pin)
    else $error("minus leg high longer than one bit");
  eop_len_a: assert property (
    (tx_plus_pin && !tx_minus_pin) [*7] |-> 1'b0)
    else $error("end sequence runs too long");
  // Pre-emphasis legs must follow the line down once the end is sent
  idle_quiet_a: assert property (
    $fell(tx_plus_pin) && !tx_minus_pin && !$past(tx_minus_pin) |=>
    (!tx_plus_preemphasis_pin && !tx_minus_preemphasis_pin) [*3])
    else $error("pre-emphasis active after the end sequence");
  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule // tbs_serdes_props

bind tbs_serdes tbs_serdes_props i_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .tx_plus_pin(tx_plus_pin),
  .tx_minus_pin(tx_minus_pin),
  .tx_plus_preemphasis_pin(tx_plus_preemphasis_pin),
  .tx_minus_preemphasis_pin(tx_minus_preemphasis_pin));

/* sim/tbs_line_model.sv */
// Far end of the twisted pair: sends one Manchester frame per request
`timescale 1ns/1ps
module tbs_line_model (
  input  wire logic        hclk,
  input  wire logic        req,
  input  wire logic        inv,
  input  wire logic [5:0]  len,
  input  wire logic [31:0] dat,
  output logic             ack,
  output logic             rx_p,
  output logic             rx_m
);
  logic [47:0] s;
  logic        b;
  initial begin
    ack = 1'b0;
    rx_p = 1'b0;
    rx_m = 1'b0;
    forever begin
      @(posedge hclk iff req === 1'b1);
      s = {dat, 16'hAB55};
      // Preamble and start pattern first, every word LSB first
      for (int i = 0; i < 16 + len; i++) begin
        b = s[i] ^ inv;
        rx_p <= ~b;
        rx_m <= b;
        @(posedge hclk);
        rx_p <= b;
        rx_m <= ~b;
        @(posedge hclk);
      end
      // Equal legs end the carrier; long enough for the squelch
      rx_p <= 1'b0;
      rx_m <= 1'b0;
      repeat (8) @(posedge hclk);
      ack <= 1'b1;
      @(posedge hclk);
      ack <= 1'b0;
    end
  end
endmodule // tbs_line_model

/* sim/tb.sv */
// Self-checking bench for the 10Base-T serializer block
`timescale 1ns/1ps
module tb;
  import tbs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, req, inv, ack, rx_p, rx_m;
  logic        hreadyout, hresp, txp, txm, txpe, txme, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  len;
  logic [15:0] d;
  logic [31:0] haddr, hwdata, hrdata, rd, dat;
  int          bad_count, n_checks, cyc, cfg, ext, n;

  tbs_serdes i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .analog_rx_plus(rx_p),
    .analog_rx_minus(rx_m), .tx_plus_pin(txp), .tx_minus_pin(txm),
    .tx_plus_preemphasis_pin(txpe), .tx_minus_preemphasis_pin(txme),
    .irq(irq));
  tbs_line_model i_line (.hclk(hclk), .req(req), .inv(inv), .len(len),
    .dat(dat), .ack(ack), .rx_p(rx_p), .rx_m(rx_m));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  // Partial word at end of packet: the bits after the first full word
  function automatic logic [31:0] tail(input logic [31:0] v, input int sh,
                                       input int w);
    return (v >> sh) & ((32'h1 << w) - 32'h1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {hresetn, hsel, hwrite, req, inv} = 5'h00;
    {htrans, hsize, len, haddr, hwdata, dat} = '0;
    void'($urandom(32'hF4932AD1));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_RXCFG, 32'h0);
    chk(rd, 32'h10);
    bus(1'b1, 8'h3C, 32'hFFFF);
    bus(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    chk({28'h0, txp, txm, txpe, txme}, 32'h0);
    bus(1'b1, OFS_INTEN, 32'h7);
    bus(1'b1, OFS_SYNC, $urandom % 256);
    // Pass 1 plain, pass 2 inverted legs, pass 3 wrong master clock
    for (int k = 0; k < 3; k++) begin
      cfg = 4 + $urandom % 13;
      ext = 1 + $urandom % (cfg - 1);
      dat <= ($urandom << 8) | 32'hAB;
      inv <= (k == 1);
      len <= 6'(cfg + ext);
      bus(1'b1, OFS_RXCFG, cfg);
      bus(1'b1, OFS_MODE,
          k == 2 ? 32'h01 : (k == 1 ? 32'h31 : 32'h21));
      req <= 1'b1;
      // Mid-frame the live carrier must show; software's collision test
      repeat (30) @(posedge hclk);
      bus(1'b0, OFS_RXCNT, 32'h0);
      chk(rd & 32'h20, 32'h20);
      n = 0;
      do @(posedge hclk); while (ack !== 1'b1 && ++n < 300);
      chk({31'h0, ack}, 32'h1);
      req <= 1'b0;
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk(rd & 32'h9, k == 2 ? 32'h0 : 32'h9);
      chk({31'h0, irq}, {31'h0, k != 2});
      if (k < 2) begin
        bus(1'b0, OFS_RXCNT, 32'h0);
        chk(rd & 32'h1F, ext);
        bus(1'b0, OFS_RXBUF, 32'h0);
        chk(rd, tail(dat, cfg, ext));
      end
      bus(1'b1, OFS_FLAGS, 32'h1F);
    end
    bus(1'b1, OFS_MODE, 32'h21);
    for (int k = 0; k < 2; k++) begin
      n = k ? 1 + $urandom % 16 : 16;
      d = 16'($urandom);
      bus(1'b1, OFS_TXCFG, n);
      bus(1'b1, OFS_TXBUFH, {24'h0, d[15:8]});
      repeat (6) @(posedge hclk);
      chk({31'h0, txp | txm}, 32'h0);
      bus(1'b1, OFS_TXBUFL, {24'h0, d[7:0]});
      ext = 0;
      do @(negedge hclk); while (txp !== 1'b1 && txm !== 1'b1 && ++ext < 50);
      chk({31'h0, txp | txm}, 32'h1);
      for (int i = 0; i < n; i++) begin
        chk({30'h0, txp, txm}, {30'h0, ~d[i], d[i]});
        @(negedge hclk);
        chk({30'h0, txp, txm}, {30'h0, d[i], ~d[i]});
        @(negedge hclk);
      end
      for (int i = 0; i < 5; i++) begin
        chk({30'h0, txp, txm}, 32'h2);
        @(negedge hclk);
      end
      @(negedge hclk);
      chk({28'h0, txp, txm, txpe, txme}, 32'h0);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk(rd & 32'h6, 32'h6);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, OFS_FLAGS, 32'h1F);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
    end
    end_sim();
  end
endmodule // tb
